// ===== econ_clk_defines.vh
// register offsets, field positions, reset values and timing counts
// of the economy-clock and power-down controller; included by bare name
`ifndef ECON_CLK_DEFINES_VH
`define ECON_CLK_DEFINES_VH

// byte addresses on the register bus
`define OFS_PMR 4'h0
`define OFS_EXT_INTERRUPT_FLAG_REG 4'h4
`define OFS_STATUS 4'h8
`define OFS_POWER_CONTROL_REG 4'hc

// power management register fields
`define PMR_DIV_HI 7
`define PMR_DIV_LO 6
`define PMR_SWB 5
`define PMR_CRYSTAL_AMP_OFF 3
`define PMR_RESET 8'h40

// external interrupt flag register fields
`define EXT_INTERRUPT_FLAG_REG_SRC_SEL 3
`define EXT_INTERRUPT_FLAG_REG_SRC_IND 2
`define EXT_INTERRUPT_FLAG_REG_RC_WAKE 1

// status and power control fields
`define STATUS_XTAL_RDY 4
`define POWER_CONTROL_REG_PD 1
`define POWER_CONTROL_REG_IDLE 0

// divide codes and terminal counts of the machine-cycle counter
`define DIV_RSVD 2'b00
`define DIV_4 2'b01
`define DIV_64 2'b10
`define DIV_1024 2'b11
`define TERM_4 10'h003
`define TERM_64 10'h03f
`define TERM_1024 10'h3ff

// default crystal warm-up count in clocks
`define XTAL_WARMUP_DEFAULT 16384

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== machine_cycle_divider.v
// machine-cycle enable generator: one aclk domain, no gated clocks
// assumes the parent holds reset for every reset source
`timescale 1ns/1ps
`include "econ_clk_defines.vh"

module machine_cycle_divider (
  input wire aclk,
  input wire rst,
  input wire run,
  input wire idle,
  input wire [1:0] divide,
  output wire machine_tick,
  output wire core_cycle_en,
  output wire periph_cycle_en
);

  reg [9:0] count;
  reg [9:0] term;

  always @*
  begin
    case (divide)
      `DIV_64: term = `TERM_64;
      `DIV_1024: term = `TERM_1024;
      default: term = `TERM_4;
    endcase
  end

  always @(posedge aclk)
  begin
    if (rst)
      count <= 10'h000;
    else if (run)
    begin
      if (count >= term)
        count <= 10'h000;
      else
        count <= count + 10'h001;
    end
  end

  assign machine_tick = run && (count >= term);
  assign core_cycle_en = machine_tick && !idle;
  // idle peripherals at clock/4, else core rate
  assign periph_cycle_en = idle ? (run && (count[1:0] == 2'b11)) : machine_tick;

endmodule // machine_cycle_divider

// ===== economy_clock_and_power_down.v
// economy clock rate, clock source and power-down controller
// assumes inputs synchronous to aclk; registers reached over AXI4-Lite
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "econ_clk_defines.vh"

// Summary of operation
// - divide code picks 4, 64, 1024 clocks
// - peripherals follow core rate; idle runs clock/4
// - new divide applies after one instruction cycle
// - select bit picks crystal or RC oscillator
// - amp-off bit stops crystal while on RC
// - read-only indicator shows active clock source
// - source change applies after one instruction cycle
// - clear amp-off first; ready flag after warm-up
// - crystal select refused while not ready
// - switchback restores divide-by-4 on events
// - rx start-bit falling edge triggers switchback
// - transmit buffer write triggers switchback
// - serial interrupt flags do not affect switchback
// - divide writes ignored during serial activity with switchback on
// - every reset source forces divide-by-4
// - power-down bit halts clocks; RC oscillator keeps running if selected
// - power-down drives strobes low, port0 floats with external program memory
// - reset pin ends power-down, restart at zero
// - watchdog cannot wake from power-down
// - level external interrupt wakes, runs handler
// - rc-wake select wakes on RC, then crystal
module economy_clock_and_power_down #(
  parameter XTAL_WARMUP_CYCLES = `XTAL_WARMUP_DEFAULT
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rst_pin,
  input wire watchdog_reset,
  input wire power_fail_reset,
  input wire ext_int_ack,
  input wire [1:0] ext_int_n,
  input wire [1:0] ext_int_enable,
  input wire [1:0] ext_int_level_mode,
  input wire global_interrupt_enable,
  input wire serial_rx_enable,
  input wire serial_rx_line,
  input wire serial_tx_buffer_write,
  input wire serial_busy,
  input wire external_program_mem,
  output wire core_cycle_en,
  output wire periph_cycle_en,
  output reg core_reset,
  output reg wake_to_isr,
  output reg clock_source_indicator,
  output wire crystal_amp_enable,
  output wire rc_osc_enable,
  output wire ale_force_low,
  output wire program_store_strobe_force_low,
  output wire port0_float,
  output wire ports_hold_registers
);

  localparam ST_RUN = 3'b001;
  localparam ST_DOWN = 3'b010;
  localparam ST_WARM = 3'b100;

  reg [2:0] state;
  reg [1:0] divide_active;
  reg [1:0] divide_pend;
  reg divide_changed;
  reg switchback_enable;
  reg crystal_amp_off;
  reg clock_source_select;
  reg src_changed;
  reg rc_wake_select;
  reg auto_to_crystal;
  reg idle_bit;
  reg crystal_ready_flag;
  reg [15:0] warm_count;
  reg rx_line_prev;
  reg [3:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  reg [7:0] rd_byte;
  reg rd_hit;

  wire rst;
  wire powered_down;
  wire machine_tick;
  wire switchback;
  wire level_wake;
  wire wr_fire;
  wire wr_byte0;
  wire [7:0] wb;

  assign powered_down = (state == ST_DOWN) || (state == ST_WARM);

  // any reset source forces the defaults
  // watchdog reset is blocked in power-down
  assign rst = !aresetn || power_fail_reset || rst_pin || (watchdog_reset && !powered_down);

  // enabled level-mode interrupt held low, global enable set
  assign level_wake = global_interrupt_enable && |(~ext_int_n & ext_int_enable & ext_int_level_mode);

  // switchback on acknowledged interrupt or serial event
  // start-bit falling edge while reception enabled
  // any write to the transmit buffer
  // serial interrupt flags are not looked at
  assign switchback = switchback_enable && (ext_int_ack || serial_tx_buffer_write ||
                      (serial_rx_enable && rx_line_prev && !serial_rx_line));

  machine_cycle_divider divider (
    .aclk(aclk),
    .rst(rst),
    .run(state == ST_RUN),
    .idle(idle_bit),
    .divide(divide_active),
    .machine_tick(machine_tick),
    .core_cycle_en(core_cycle_en),
    .periph_cycle_en(periph_cycle_en)
  );

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
  wire [3:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  assign wr_byte0 = wr_fire && wr_strb[0];
  assign wb = wr_data[7:0];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr == `OFS_PMR || wr_addr == `OFS_EXT_INTERRUPT_FLAG_REG || wr_addr == `OFS_STATUS ||
                        wr_addr == `OFS_POWER_CONTROL_REG) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  always @*
  begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    case (s_axi_araddr)
      `OFS_PMR:
      begin
        rd_byte[`PMR_DIV_HI:`PMR_DIV_LO] = divide_active;
        rd_byte[`PMR_SWB] = switchback_enable;
        rd_byte[`PMR_CRYSTAL_AMP_OFF] = crystal_amp_off;
      end
      `OFS_EXT_INTERRUPT_FLAG_REG:
      begin
        rd_byte[`EXT_INTERRUPT_FLAG_REG_SRC_SEL] = clock_source_select;
        // indicator shows the source in use
        rd_byte[`EXT_INTERRUPT_FLAG_REG_SRC_IND] = clock_source_indicator;
        rd_byte[`EXT_INTERRUPT_FLAG_REG_RC_WAKE] = rc_wake_select;
      end
      `OFS_STATUS: rd_byte[`STATUS_XTAL_RDY] = crystal_ready_flag;
      `OFS_POWER_CONTROL_REG:
      begin
        rd_byte[`POWER_CONTROL_REG_PD] = powered_down;
        rd_byte[`POWER_CONTROL_REG_IDLE] = idle_bit;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // crystal warm-up tracking
  // amp off in power-down, else only while running from RC
  // amp runs again in warm-up so the ready flag can rise
  assign crystal_amp_enable = (state != ST_DOWN) && !(crystal_amp_off && !clock_source_indicator);
  assign rc_osc_enable = !powered_down || !clock_source_indicator;

  always @(posedge aclk)
  begin
    if (rst)
    begin
      warm_count <= 16'h0000;
      crystal_ready_flag <= 1'b1;
    end
    else if (!crystal_amp_enable)
    begin
      warm_count <= 16'h0000;
      crystal_ready_flag <= 1'b0;
    end
    // ready flag set once warm-up has elapsed
    else if (!crystal_ready_flag)
    begin
      if (warm_count >= XTAL_WARMUP_CYCLES[15:0] - 16'h0001)
        crystal_ready_flag <= 1'b1;
      else
        warm_count <= warm_count + 16'h0001;
    end
  end

  // control registers, clock selection and power state
  always @(posedge aclk)
  begin
    if (rst)
    begin
      state <= ST_RUN;
      divide_active <= `DIV_4;
      divide_pend <= `DIV_4;
      divide_changed <= 1'b0;
      switchback_enable <= 1'b0;
      crystal_amp_off <= 1'b0;
      clock_source_select <= 1'b1;
      clock_source_indicator <= 1'b1;
      src_changed <= 1'b0;
      rc_wake_select <= 1'b0;
      auto_to_crystal <= 1'b0;
      idle_bit <= 1'b0;
      wake_to_isr <= 1'b0;
      rx_line_prev <= 1'b1;
    end
    else
    begin
      rx_line_prev <= serial_rx_line;
      wake_to_isr <= 1'b0;
      case (state)
        ST_RUN:
        begin
          // pending divide applied at next machine cycle
          if (divide_changed && machine_tick)
          begin
            divide_active <= divide_pend;
            divide_changed <= 1'b0;
          end
          // pending source applied at next machine cycle
          if (src_changed && machine_tick)
          begin
            clock_source_indicator <= clock_source_select;
            src_changed <= 1'b0;
          end
          // return to crystal once it is stable
          if (auto_to_crystal && crystal_ready_flag)
          begin
            clock_source_indicator <= clock_source_select;
            auto_to_crystal <= 1'b0;
          end
          if (ext_int_ack)
            idle_bit <= 1'b0;
          if (wr_byte0 && wr_addr == `OFS_PMR)
          begin
            switchback_enable <= wb[`PMR_SWB];
            crystal_amp_off <= wb[`PMR_CRYSTAL_AMP_OFF];
            // new code takes one of the three rates
            // reserved code leaves the setting alone
            // ignored during serial activity with switchback on
            if (wb[`PMR_DIV_HI:`PMR_DIV_LO] != `DIV_RSVD && !(switchback_enable && serial_busy))
            begin
              divide_pend <= wb[`PMR_DIV_HI:`PMR_DIV_LO];
              divide_changed <= 1'b1;
            end
          end
          if (wr_byte0 && wr_addr == `OFS_EXT_INTERRUPT_FLAG_REG)
          begin
            rc_wake_select <= wb[`EXT_INTERRUPT_FLAG_REG_RC_WAKE];
            if (!wb[`EXT_INTERRUPT_FLAG_REG_SRC_SEL] || crystal_ready_flag)
            begin
              clock_source_select <= wb[`EXT_INTERRUPT_FLAG_REG_SRC_SEL];
              src_changed <= 1'b1;
            end
          end
          if (wr_byte0 && wr_addr == `OFS_POWER_CONTROL_REG)
            idle_bit <= wb[`POWER_CONTROL_REG_IDLE] && !wb[`POWER_CONTROL_REG_PD];
          // power-down write is the last instruction
          if (wr_byte0 && wr_addr == `OFS_POWER_CONTROL_REG && wb[`POWER_CONTROL_REG_PD])
          begin
            state <= ST_DOWN;
            idle_bit <= 1'b0;
          end
          // switchback wins over a same-cycle divide write
          if (switchback)
          begin
            divide_active <= `DIV_4;
            divide_pend <= `DIV_4;
            divide_changed <= 1'b0;
          end
        end
        ST_DOWN:
        begin
          if (level_wake)
          begin
            if (rc_wake_select && clock_source_indicator)
            begin
              clock_source_indicator <= 1'b0;
              auto_to_crystal <= 1'b1;
              state <= ST_RUN;
              wake_to_isr <= 1'b1;
            end
            else if (clock_source_indicator)
              state <= ST_WARM;
            else
            begin
              state <= ST_RUN;
              wake_to_isr <= 1'b1;
            end
          end
        end
        ST_WARM:
        begin
          if (crystal_ready_flag)
          begin
            state <= ST_RUN;
            wake_to_isr <= 1'b1;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // any reset, reset pin included, restarts at address zero
  always @(posedge aclk)
  begin
    if (!aresetn)
      core_reset <= 1'b1;
    else
      core_reset <= rst;
  end

  assign ale_force_low = powered_down;
  assign program_store_strobe_force_low = powered_down;
  assign port0_float = powered_down && external_program_mem;
  assign ports_hold_registers = powered_down;

endmodule // economy_clock_and_power_down

// ===== econ_clk_properties.sv
// timing checks of the economy clock and power-down controller
// assumes binding onto the controller top, single aclk domain
`timescale 1ns/1ps
module econ_clk_properties (
  input wire aclk,
  input wire aresetn,
  input wire rst_pin,
  input wire watchdog_reset,
  input wire power_fail_reset,
  input wire external_program_mem,
  input wire core_cycle_en,
  input wire periph_cycle_en,
  input wire core_reset,
  input wire wake_to_isr,
  input wire clock_source_indicator,
  input wire crystal_amp_enable,
  input wire ale_force_low,
  input wire program_store_strobe_force_low,
  input wire port0_float,
  input wire ports_hold_registers,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  pd_pins_a: assert property (ale_force_low |-> program_store_strobe_force_low && ports_hold_registers
    && !core_cycle_en && !periph_cycle_en) else $error("pins or clocks active in power-down");
  port0_float_a: assert property (port0_float == (ale_force_low && external_program_mem))
    else $error("port0 float wrong");
  ext_reset_a: assert property ((rst_pin || power_fail_reset) |=> core_reset)
    else $error("reset input did not reset core");
  wdog_pd_a: assert property ((ale_force_low && watchdog_reset && !rst_pin && !power_fail_reset && !core_reset)
    |=> !core_reset) else $error("watchdog woke power-down");
  // outside power-down the crystal amp is off only while running from RC
  amp_off_a: assert property (!crystal_amp_enable && !ale_force_low |-> !clock_source_indicator)
    else $error("running on crystal with amplifier off");
  cycle_gap_a: assert property ((core_cycle_en && !core_reset && !rst_pin && !watchdog_reset && !power_fail_reset)
    |=> !core_cycle_en [*3]) else $error("machine cycle shorter than 4");
  wake_pulse_a: assert property (wake_to_isr |=> !wake_to_isr)
    else $error("wake pulse too long");
  wake_run_a: assert property (wake_to_isr |-> !ale_force_low)
    else $error("wake while still powered down");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  wake_c: cover property (wake_to_isr);
  float_c: cover property (ale_force_low && port0_float);
  rc_c: cover property ($fell(clock_source_indicator));
endmodule // econ_clk_properties

bind economy_clock_and_power_down econ_clk_properties chk_u (
  .aclk(aclk), .aresetn(aresetn), .rst_pin(rst_pin), .watchdog_reset(watchdog_reset),
  .power_fail_reset(power_fail_reset), .external_program_mem(external_program_mem),
  .core_cycle_en(core_cycle_en), .periph_cycle_en(periph_cycle_en), .core_reset(core_reset),
  .wake_to_isr(wake_to_isr), .clock_source_indicator(clock_source_indicator),
  .crystal_amp_enable(crystal_amp_enable), .ale_force_low(ale_force_low),
  .program_store_strobe_force_low(program_store_strobe_force_low), .port0_float(port0_float),
  .ports_hold_registers(ports_hold_registers), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata)
);

// ===== tb_economy_clock_and_power_down.sv
// self-checking bench of the economy clock and power-down controller
// assumes the controller with a short crystal warm-up, driven over AXI4-Lite
`timescale 1ns/1ps
module tb_economy_clock_and_power_down;
  reg aclk = 1'h0, aresetn = 1'h0;
  reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  reg rst_pin = 1'h0, watchdog_reset = 1'h0, power_fail_reset = 1'h0, ext_int_ack = 1'h0;
  reg [1:0] ext_int_n = 2'h3, ext_int_enable = 2'h0, ext_int_level_mode = 2'h0;
  reg global_interrupt_enable = 1'h0, serial_rx_enable = 1'h0, serial_rx_line = 1'h1;
  reg serial_tx_buffer_write = 1'h0, serial_busy = 1'h0, external_program_mem = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire core_cycle_en, periph_cycle_en, core_reset, wake_to_isr, clock_source_indicator;
  wire crystal_amp_enable, rc_osc_enable, ale_force_low, program_store_strobe_force_low;
  wire port0_float, ports_hold_registers;
  integer n_errors = 0, tests_run = 0, i;

  economy_clock_and_power_down #(.XTAL_WARMUP_CYCLES(8)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rst_pin(rst_pin), .watchdog_reset(watchdog_reset), .power_fail_reset(power_fail_reset),
    .ext_int_ack(ext_int_ack), .ext_int_n(ext_int_n), .ext_int_enable(ext_int_enable),
    .ext_int_level_mode(ext_int_level_mode), .global_interrupt_enable(global_interrupt_enable),
    .serial_rx_enable(serial_rx_enable), .serial_rx_line(serial_rx_line),
    .serial_tx_buffer_write(serial_tx_buffer_write), .serial_busy(serial_busy),
    .external_program_mem(external_program_mem), .core_cycle_en(core_cycle_en),
    .periph_cycle_en(periph_cycle_en), .core_reset(core_reset), .wake_to_isr(wake_to_isr),
    .clock_source_indicator(clock_source_indicator), .crystal_amp_enable(crystal_amp_enable),
    .rc_osc_enable(rc_osc_enable), .ale_force_low(ale_force_low),
    .program_store_strobe_force_low(program_store_strobe_force_low), .port0_float(port0_float),
    .ports_hold_registers(ports_hold_registers)
  );

  always #10 aclk = ~aclk;

  task finish_test;
    begin
      $display("errors %0d of %0d compares", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task check(input [31:0] s, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e)
      begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask

  task wr(input [3:0] a, input [7:0] d, input [1:0] er);
    reg aw, w;
    begin
      aw = 1'h1;
      w = 1'h1;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      @(posedge aclk);
      while (!(s_axi_bvalid && !aw && !w))
      begin
        if (aw && s_axi_awready)
        begin
          aw = 1'h0;
          s_axi_awvalid <= 1'h0;
        end
        if (w && s_axi_wready)
        begin
          w = 1'h0;
          s_axi_wvalid <= 1'h0;
        end
        @(posedge aclk);
      end
      check(s_axi_bresp, er);
    end
  endtask

  task rd(input [3:0] a, input [7:0] e, input [1:0] er);
    reg ar;
    begin
      ar = 1'h1;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      @(posedge aclk);
      while (!(s_axi_rvalid && !ar))
      begin
        if (ar && s_axi_arready)
        begin
          ar = 1'h0;
          s_axi_arvalid <= 1'h0;
        end
        @(posedge aclk);
      end
      check(s_axi_rdata, {24'h0, e});
      check(s_axi_rresp, er);
    end
  endtask

  // clocks between two machine-cycle pulses, second period after a change
  task prd(input [31:0] e);
    reg [31:0] p;
    begin
      repeat (2)
      begin
        @(posedge aclk);
        while (!core_cycle_en) @(posedge aclk);
        @(posedge aclk);
        p = 32'h1;
        while (!core_cycle_en)
        begin
          @(posedge aclk);
          p = p + 1;
        end
      end
      check(p, e);
    end
  endtask

  task cnt(input [31:0] ec, input [31:0] ep);
    reg [31:0] c, pc;
    begin
      c = 32'h0;
      pc = 32'h0;
      repeat (128)
      begin
        @(posedge aclk);
        c = c + core_cycle_en;
        pc = pc + periph_cycle_en;
      end
      check(c, ec);
      check(pc, ep);
    end
  endtask

  task pulse_ack;
    begin
      ext_int_ack <= 1'h1;
      @(posedge aclk);
      ext_int_ack <= 1'h0;
      @(posedge aclk);
    end
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(4'h0, 8'h40, 2'h0);
    rd(4'h4, 8'h0c, 2'h0);
    rd(4'h8, 8'h10, 2'h0);
    rd(4'h2, 8'h00, 2'h2);
    prd(32'h4);
    wr(4'h0, 8'h80, 2'h0);
    prd(32'h40);
    cnt(32'h2, 32'h2);
    // back to divide-by-4 and settled before the other slow rate
    wr(4'h0, 8'h40, 2'h0);
    prd(32'h4);
    wr(4'h0, 8'hc0, 2'h0);
    prd(32'h400);
    wr(4'h0, 8'h00, 2'h0);
    rd(4'h0, 8'hc0, 2'h0);
    prd(32'h400);
    wr(4'h0, 8'h40, 2'h0);
    prd(32'h4);
    wr(4'h0, 8'h80, 2'h0);
    wr(4'hc, 8'h01, 2'h0);
    cnt(32'h0, 32'h20);
    pulse_ack;
    wr(4'h0, 8'h40, 2'h0);
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(4'h0, 8'ha0, 2'h0);
      prd(32'h40);
      if (i == 0)
        serial_tx_buffer_write <= 1'h1;
      serial_rx_enable <= (i == 1);
      serial_rx_line <= (i != 1);
      ext_int_ack <= (i == 2);
      @(posedge aclk);
      serial_tx_buffer_write <= 1'h0;
      serial_rx_line <= 1'h1;
      ext_int_ack <= 1'h0;
      prd(32'h4);
    end
    serial_busy <= 1'h1;
    wr(4'h0, 8'he0, 2'h0);
    // an accepted write would move to divide-by-1024 here
    prd(32'h4);
    rd(4'h0, 8'h60, 2'h0);
    serial_busy <= 1'h0;
    wr(4'h4, 8'h00, 2'h0);
    prd(32'h4);
    check(clock_source_indicator, 1'h0);
    wr(4'h0, 8'h48, 2'h0);
    check(crystal_amp_enable, 1'h0);
    check(rc_osc_enable, 1'h1);
    wr(4'h4, 8'h08, 2'h0);
    prd(32'h4);
    check(clock_source_indicator, 1'h0);
    rd(4'h8, 8'h00, 2'h0);
    wr(4'h0, 8'h40, 2'h0);
    repeat (20) @(posedge aclk);
    rd(4'h8, 8'h10, 2'h0);
    wr(4'h4, 8'h08, 2'h0);
    prd(32'h4);
    check(clock_source_indicator, 1'h1);
    wr(4'h0, 8'h80, 2'h0);
    external_program_mem <= 1'h1;
    wr(4'hc, 8'h02, 2'h0);
    @(posedge aclk);
    check(ale_force_low, 1'h1);
    check(program_store_strobe_force_low, 1'h1);
    check(ports_hold_registers, 1'h1);
    check(port0_float, 1'h1);
    check(core_cycle_en, 1'h0);
    watchdog_reset <= 1'h1;
    repeat (4) @(posedge aclk);
    watchdog_reset <= 1'h0;
    @(posedge aclk);
    check(ale_force_low, 1'h1);
    rst_pin <= 1'h1;
    repeat (3) @(posedge aclk);
    rst_pin <= 1'h0;
    @(posedge aclk);
    check(core_reset, 1'h1);
    repeat (4) @(posedge aclk);
    check(ale_force_low, 1'h0);
    rd(4'h0, 8'h40, 2'h0);
    // watchdog reset while running restores divide-by-4
    wr(4'h0, 8'h80, 2'h0);
    prd(32'h40);
    watchdog_reset <= 1'h1;
    @(posedge aclk);
    watchdog_reset <= 1'h0;
    @(posedge aclk);
    rd(4'h0, 8'h40, 2'h0);
    prd(32'h4);
    ext_int_enable <= 2'h1;
    ext_int_level_mode <= 2'h1;
    global_interrupt_enable <= 1'h1;
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(4'h4, i ? 8'h0a : 8'h08, 2'h0);
      wr(4'hc, 8'h02, 2'h0);
      ext_int_n <= 2'h2;
      @(posedge aclk);
      while (!wake_to_isr) @(posedge aclk);
      check(clock_source_indicator, i ? 1'h0 : 1'h1);
      check(ale_force_low, 1'h0);
      ext_int_n <= 2'h3;
    end
    repeat (30) @(posedge aclk);
    check(clock_source_indicator, 1'h1);
    finish_test;
  end

  // about twice the length of the scenarios above
  initial
  begin
    #400000;
    n_errors = n_errors + 1;
    finish_test;
  end
endmodule // tb_economy_clock_and_power_down
